// File: verilog/mad_pkg.sv
// Shared constants and types of the motion activity detector.
package mad_pkg;

   localparam int SMP_W   = 12;
   localparam int THR_W   = 11;
   localparam int ATIME_W = 8;
   localparam int ITIME_W = 16;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ACT_THR    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ACT_TIME   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INACT_THR  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_INACT_TIME = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CTL        = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PWR        = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_MAP_FIRST  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_MAP_SECOND = 8'h20;

   // Status bits.
   localparam int ST_ACT   = 0;
   localparam int ST_INACT = 1;
   localparam int ST_AWAKE = 2;
   localparam int ST_WAKE  = 3;
   localparam int ST_MEAS  = 4;

   // Control bits.
   localparam int CTL_ACT_EN    = 0;
   localparam int CTL_ACT_REF   = 1;
   localparam int CTL_INACT_EN  = 2;
   localparam int CTL_INACT_REF = 3;
   localparam int CTL_LINK_LSB  = 4;
   localparam int CTL_AUTOSLEEP = 6;
   localparam int CTL_W         = 7;

   // Power bits.
   localparam int PWR_MEAS = 0;
   localparam int PWR_WAKE = 1;
   localparam int PWR_W    = 2;

   // Pin map bits: activity, inactivity, awake level.
   localparam int MAP_ACT   = 0;
   localparam int MAP_INACT = 1;
   localparam int MAP_AWAKE = 2;
   localparam int MAP_W     = 3;

   // Link mode encodings; the unused code behaves as default.
   localparam logic [1:0] LINK_DEFAULT = 2'h0;
   localparam logic [1:0] LINK_LINKED  = 2'h1;
   localparam logic [1:0] LINK_LOOP    = 2'h3;

   // Wake-up mode keeps one sample in this many: 100 Hz / 16 is about six per second.
   localparam int WAKE_DECIM = 16;

   typedef struct packed {
      logic signed [SMP_W-1:0] x;
      logic signed [SMP_W-1:0] y;
      logic signed [SMP_W-1:0] z;
   } mad_sample_t;

endpackage

// File: verilog/mad_axis_cmp.sv
// Per-axis threshold comparison for activity and inactivity.
`timescale 1ns/100ps
`default_nettype none
module mad_axis_cmp (
   // Sample and reference
   input  wire mad_pkg::mad_sample_t   smp_i,
   input  wire mad_pkg::mad_sample_t   ref_i,
   // Configuration
   input  wire logic [mad_pkg::THR_W-1:0] act_thr_i,
   input  wire logic                      act_ref_i,
   input  wire logic [mad_pkg::THR_W-1:0] inact_thr_i,
   input  wire logic                      inact_ref_i,
   // Results
   output logic                           act_hit_o,
   output logic                           inact_hit_o
);
   import mad_pkg::*;

   // Magnitude of a sample, optionally taken against the reference.
   function automatic logic [SMP_W:0] mag(input logic signed [SMP_W-1:0] a,
                                          input logic signed [SMP_W-1:0] r,
                                          input logic                    use_ref);
      logic signed [SMP_W:0] d;
      d = use_ref ? ($signed({a[SMP_W-1], a}) - $signed({r[SMP_W-1], r}))
                  : $signed({a[SMP_W-1], a});
      mag = d[SMP_W] ? (SMP_W+1)'(-d) : (SMP_W+1)'(d);
   endfunction

   logic [SMP_W:0] act_thr_w;
   logic [SMP_W:0] inact_thr_w;

   always_comb begin
      act_thr_w   = {2'h0, act_thr_i};
      inact_thr_w = {2'h0, inact_thr_i};
      // Any axis above gives activity; all axes below give inactivity.
      act_hit_o   = (mag(smp_i.x, ref_i.x, act_ref_i) > act_thr_w)
                  | (mag(smp_i.y, ref_i.y, act_ref_i) > act_thr_w)
                  | (mag(smp_i.z, ref_i.z, act_ref_i) > act_thr_w);
      inact_hit_o = (mag(smp_i.x, ref_i.x, inact_ref_i) < inact_thr_w)
                  & (mag(smp_i.y, ref_i.y, inact_ref_i) < inact_thr_w)
                  & (mag(smp_i.z, ref_i.z, inact_ref_i) < inact_thr_w);
   end
endmodule
`default_nettype wire

// File: verilog/mad_run_timer.sv
// Counter of uninterrupted runs of qualifying samples.
`timescale 1ns/100ps
`default_nettype none
module mad_run_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Sample stream
   input  wire logic         step_i,
   input  wire logic         qual_i,
   input  wire logic         clear_i,
   input  wire logic [W-1:0] limit_i,
   // Result
   output logic              hit_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } mad_tmr_state_t;

   mad_tmr_state_t st_r;
   mad_tmr_state_t st_nxt;
   logic [W:0]     run_len;

   always_comb begin
      st_nxt  = st_r;
      run_len = {1'b0, st_r.cnt} + {{W{1'b0}}, 1'b1};
      // A limit of zero or one means a single sample; no shorter run ever fires.
      hit_o   = step_i & qual_i & (run_len >= {1'b0, limit_i});
      if (clear_i) begin
         st_nxt.cnt = '0;
      end else if (step_i) begin
         if (!qual_i || hit_o) begin
            st_nxt.cnt = '0;
         end else begin
            st_nxt.cnt = run_len[W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// File: verilog/mad_detector.sv
// Activity and inactivity detection with linking, autosleep and register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Activity fires only after samples stay above threshold for the activity time.
// - Absolute activity compares each sample directly with the threshold.
// - Referenced activity compares sample minus stored reference with the threshold.
// - Reference captured on enable, on either event when linked or looped, on activity otherwise.
// - Software sets activity threshold and time, one sample up to 255 samples.
// - Activity timer only in measurement mode; wake-up mode uses one sample.
// - Inactivity fires below threshold for the inactivity time, absolute or referenced.
// - Absolute inactivity needs the programmed count of consecutive samples below threshold.
// - Referenced inactivity uses sample minus reference below the threshold.
// - Inactivity time counts one up to 65535 samples.
// - Inactivity never reported before the whole configured period stays stationary.
// - Default mode keeps both detectors on; each event waits until host reads it.
// - Linked mode runs only one detector, alternating after each event.
// - Linked mode does not arm the next detection until host services the current.
// - Loop mode alternates like linked mode without waiting for the host.
// - Autosleep in linked or loop mode enters wake-up on inactivity, leaves on activity.
// - Autosleep is ignored in default mode.
// - Awake flag sets on activity and clears on inactivity.
// - Awake flag can be routed to either interrupt pin as a level.
// - Each event is recorded in status and can drive an interrupt pin.
// - Detection runs in measurement mode and in wake-up mode.
// - Wake-up mode takes only about six samples per second.
// - Standby keeps pending flags and raises no new interrupts.
module mad_detector #(
   parameter int WAKE_DIV = mad_pkg::WAKE_DECIM
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Sample stream
   input  wire mad_pkg::mad_sample_t         sample_i,
   input  wire logic                         sample_valid_i,
   // Register port
   input  wire logic [mad_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [mad_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic [mad_pkg::DATA_W-1:0]        reg_rdata_o,
   // Pins and status
   output logic                              irq_pin_first_o,
   output logic                              irq_pin_second_o,
   output logic                              awake_o,
   output logic                              wake_mode_o,
   output logic                              measuring_o
);
   import mad_pkg::*;

   // Wake-up decimation counter width and its wrap value.
   localparam int DEC_W = (WAKE_DIV > 1) ? $clog2(WAKE_DIV) : 1;
   localparam logic [DEC_W-1:0] DEC_LAST = DEC_W'(WAKE_DIV - 1);
   localparam logic [ATIME_W-1:0] ONE_SAMPLE = 8'h01;

   // All state of the detector except the two run timers, registered as one word.
   typedef struct packed {
      logic [THR_W-1:0]   act_thr;
      logic [ATIME_W-1:0] act_time;
      logic [THR_W-1:0]   inact_thr;
      logic [ITIME_W-1:0] inact_time;
      logic [CTL_W-1:0]   ctl;
      logic [PWR_W-1:0]   pwr;
      logic [MAP_W-1:0]   map_first;
      logic [MAP_W-1:0]   map_second;
      logic               ev_act;
      logic               ev_inact;
      logic               awake;
      logic               ref_pend;
      logic               act_live;
      mad_sample_t        ref_smp;
      logic [DEC_W-1:0]   dec_cnt;
      logic [DATA_W-1:0]  rdata;
      logic               irq_first;
      logic               irq_second;
   } mad_state_t;

   // Pin level from a map and the three sources.
   function automatic logic pin_level(input logic [MAP_W-1:0] map,
                                      input logic             act,
                                      input logic             inact,
                                      input logic             awk);
      pin_level = (map[MAP_ACT] & act) | (map[MAP_INACT] & inact) | (map[MAP_AWAKE] & awk);
   endfunction

   mad_state_t st_r;
   mad_state_t st_nxt;

   logic [1:0]         link;
   logic               linked_any;
   logic               auto_on;
   logic               meas_on;
   logic               wake_mode;
   logic               act_en;
   logic               inact_en;

   logic               take;
   logic               eval;
   logic               act_arm;
   logic               inact_arm;

   logic               act_q;
   logic               inact_q;
   logic               act_hit;
   logic               inact_hit;
   logic               act_fire;
   logic               inact_fire;

   logic               act_live_now;
   logic               rd_status;
   logic [ATIME_W-1:0] act_limit;
   logic [DATA_W-1:0]  rd_word;

   mad_axis_cmp u_cmp (
      .smp_i       (sample_i),
      .ref_i       (st_r.ref_smp),
      .act_thr_i   (st_r.act_thr),
      .act_ref_i   (st_r.ctl[CTL_ACT_REF]),
      .inact_thr_i (st_r.inact_thr),
      .inact_ref_i (st_r.ctl[CTL_INACT_REF]),
      .act_hit_o   (act_q),
      .inact_hit_o (inact_q)
   );

   mad_run_timer #(.W(ATIME_W)) u_act_tmr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .step_i  (eval & act_arm),
      .qual_i  (act_q),
      .clear_i (!act_arm),
      .limit_i (act_limit),
      .hit_o   (act_hit)
   );

   mad_run_timer #(.W(ITIME_W)) u_inact_tmr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .step_i  (eval & inact_arm),
      .qual_i  (inact_q),
      .clear_i (!inact_arm),
      .limit_i (st_r.inact_time),
      .hit_o   (inact_hit)
   );

   always_comb begin
      link       = st_r.ctl[CTL_LINK_LSB +: 2];
      linked_any = (link == LINK_LINKED) || (link == LINK_LOOP);
      // Autosleep only counts when the detectors are linked or looped.
      auto_on    = linked_any & st_r.ctl[CTL_AUTOSLEEP];
      meas_on    = st_r.pwr[PWR_MEAS];
      // Autosleep sleeps while not awake and measures while awake.
      wake_mode  = meas_on & (auto_on ? !st_r.awake : st_r.pwr[PWR_WAKE]);
      act_en     = st_r.ctl[CTL_ACT_EN];
      inact_en   = st_r.ctl[CTL_INACT_EN];

      // Standby takes no samples, so no event can arise there.
      take = sample_valid_i & meas_on & (!wake_mode || (st_r.dec_cnt == '0));
      // The first sample after a reference request becomes the reference.
      eval = take & !st_r.ref_pend;

      // Arming picks which detector may count in this cycle.
      case (link)
         LINK_LINKED: begin
            // One detector at a time, and only after the host cleared both events.
            act_arm   = act_en & !st_r.awake & !st_r.ev_act & !st_r.ev_inact;
            inact_arm = inact_en & st_r.awake & !st_r.ev_act & !st_r.ev_inact;
         end
         LINK_LOOP: begin
            act_arm   = act_en & !st_r.awake;
            inact_arm = inact_en & st_r.awake;
         end
         default: begin
            // Both run; a pending event is not raised again until read.
            act_arm   = act_en & !st_r.ev_act;
            inact_arm = inact_en & !st_r.ev_inact;
         end
      endcase

      // Wake-up mode declares activity on one sample.
      act_limit  = wake_mode ? ONE_SAMPLE : st_r.act_time;
      act_fire   = act_hit;
      inact_fire = inact_hit;

      act_live_now = act_en & meas_on;
      rd_status    = reg_rd_i & (reg_addr_i == OFS_STATUS);

      // Unmapped addresses read as zero.
      rd_word = '0;
      case (reg_addr_i)
         OFS_STATUS: begin
            rd_word[ST_ACT]   = st_r.ev_act;
            rd_word[ST_INACT] = st_r.ev_inact;
            rd_word[ST_AWAKE] = st_r.awake;
            rd_word[ST_WAKE]  = wake_mode;
            rd_word[ST_MEAS]  = meas_on;
         end
         OFS_ACT_THR: begin
            rd_word[THR_W-1:0] = st_r.act_thr;
         end
         OFS_ACT_TIME: begin
            rd_word[ATIME_W-1:0] = st_r.act_time;
         end
         OFS_INACT_THR: begin
            rd_word[THR_W-1:0] = st_r.inact_thr;
         end
         OFS_INACT_TIME: begin
            rd_word[ITIME_W-1:0] = st_r.inact_time;
         end
         OFS_CTL: begin
            rd_word[CTL_W-1:0] = st_r.ctl;
         end
         OFS_PWR: begin
            rd_word[PWR_W-1:0] = st_r.pwr;
         end
         OFS_MAP_FIRST: begin
            rd_word[MAP_W-1:0] = st_r.map_first;
         end
         OFS_MAP_SECOND: begin
            rd_word[MAP_W-1:0] = st_r.map_second;
         end
         default: begin
            rd_word = '0;
         end
      endcase

      st_nxt = st_r;

      // Writes to status or unmapped addresses are dropped.
      if (reg_wr_i) begin
         case (reg_addr_i)
            OFS_ACT_THR: begin
               st_nxt.act_thr = reg_wdata_i[THR_W-1:0];
            end
            OFS_ACT_TIME: begin
               st_nxt.act_time = reg_wdata_i[ATIME_W-1:0];
            end
            OFS_INACT_THR: begin
               st_nxt.inact_thr = reg_wdata_i[THR_W-1:0];
            end
            OFS_INACT_TIME: begin
               st_nxt.inact_time = reg_wdata_i[ITIME_W-1:0];
            end
            OFS_CTL: begin
               st_nxt.ctl = reg_wdata_i[CTL_W-1:0];
            end
            OFS_PWR: begin
               st_nxt.pwr = reg_wdata_i[PWR_W-1:0];
            end
            OFS_MAP_FIRST: begin
               st_nxt.map_first = reg_wdata_i[MAP_W-1:0];
            end
            OFS_MAP_SECOND: begin
               st_nxt.map_second = reg_wdata_i[MAP_W-1:0];
            end
            default: begin
               st_nxt.ctl = st_r.ctl;
            end
         endcase
      end

      // Read data stands only in the cycle after the read strobe.
      st_nxt.rdata = reg_rd_i ? rd_word : '0;

      // Decimation runs only in wake-up mode; it restarts on the way in.
      if (!wake_mode) begin
         st_nxt.dec_cnt = '0;
      end else if (sample_valid_i) begin
         st_nxt.dec_cnt = (st_r.dec_cnt == DEC_LAST) ? '0 : st_r.dec_cnt + 1'b1;
      end

      // Reading status clears both events; an event of the same cycle wins.
      if (rd_status) begin
         st_nxt.ev_act   = 1'b0;
         st_nxt.ev_inact = 1'b0;
      end
      if (act_fire) begin
         st_nxt.ev_act = 1'b1;
         st_nxt.awake  = 1'b1;
      end
      if (inact_fire) begin
         st_nxt.ev_inact = 1'b1;
         st_nxt.awake    = 1'b0;
      end
      // Loop mode clears the opposite event itself so no host service is needed.
      if (link == LINK_LOOP) begin
         if (act_fire) begin
            st_nxt.ev_inact = 1'b0;
         end
         if (inact_fire) begin
            st_nxt.ev_act = 1'b0;
         end
      end

      // New reference on turn-on, after activity, and after inactivity too when linked or looped.
      st_nxt.act_live = act_live_now;
      if (act_live_now && !st_r.act_live) begin
         st_nxt.ref_pend = 1'b1;
      end else if (linked_any && (inact_fire || act_fire)) begin
         st_nxt.ref_pend = 1'b1;
      end else if (!linked_any && act_fire) begin
         st_nxt.ref_pend = 1'b1;
      end else if (take && st_r.ref_pend) begin
         st_nxt.ref_pend = 1'b0;
         st_nxt.ref_smp  = sample_i;
      end

      // Pins follow the events and the awake level after one register stage.
      st_nxt.irq_first  = pin_level(st_r.map_first, st_r.ev_act, st_r.ev_inact, st_r.awake);
      st_nxt.irq_second = pin_level(st_r.map_second, st_r.ev_act, st_r.ev_inact, st_r.awake);

      // Standby may let a pin fall but never raise it, even after a map write.
      if (!meas_on) begin
         st_nxt.irq_first  = st_nxt.irq_first & st_r.irq_first;
         st_nxt.irq_second = st_nxt.irq_second & st_r.irq_second;
      end
   end

   // Both detectors and measurement start disabled; the host turns them on.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Mode levels decode straight from registers; data and pins are registered.
   always_comb begin
      reg_rdata_o      = st_r.rdata;
      irq_pin_first_o  = st_r.irq_first;
      irq_pin_second_o = st_r.irq_second;
      awake_o          = st_r.awake;
      wake_mode_o      = wake_mode;
      measuring_o      = meas_on;
   end
endmodule
`default_nettype wire

// File: verification/mad_sensor_model.sv
// Sensor front-end model that hands one acceleration sample to the detector per request.
`timescale 1ns/100ps
`default_nettype none
module mad_sensor_model (
   // Clock
   input  wire logic                 clk_i,
   // Request from the bench
   input  wire logic                 go_i,
   input  wire mad_pkg::mad_sample_t val_i,
   // Sample stream towards the detector
   output mad_pkg::mad_sample_t      smp_o,
   output logic                      valid_o
);
   import mad_pkg::*;
   // Between samples the data lines toggle, so stale data is never mistaken for a fresh sample.
   always_ff @(posedge clk_i) begin
      valid_o <= go_i;
      smp_o   <= go_i ? val_i : ~smp_o;
   end
endmodule
`default_nettype wire

// File: verification/mad_detector_properties.sv
// Concurrent checks on the ports of the motion activity detector.
`timescale 1ns/100ps
`default_nettype none
module mad_detector_properties #(
   parameter int WAKE_DIV = 16
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       sample_valid_i,
   input  wire logic [mad_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [mad_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic                       irq_pin_first_o,
   input  wire logic                       irq_pin_second_o,
   input  wire logic                       awake_o,
   input  wire logic                       wake_mode_o,
   input  wire logic                       measuring_o
);
   import mad_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_awake_cause: assert property ($changed(awake_o) |-> $past(sample_valid_i) || $past(rst_i))
      else $error("awake flag moved without a sample");
   chk_standby_quiet: assert property (!measuring_o |=> $stable(awake_o))
      else $error("awake flag moved in standby");
   chk_status_mirror: assert property (reg_rd_i && reg_addr_i == OFS_STATUS && !sample_valid_i
      |=> reg_rdata_o[4:2] == $past({measuring_o, wake_mode_o, awake_o}))
      else $error("status read disagrees with level outputs");
   chk_status_upper: assert property (reg_rd_i && reg_addr_i == OFS_STATUS |=> reg_rdata_o[31:5] == '0)
      else $error("status upper bits not zero");
   chk_pin_first_cause: assert property ($rose(irq_pin_first_o)
      |-> $past(sample_valid_i, 2) || $past(reg_wr_i, 2))
      else $error("first pin rose without cause");
   chk_pin_second_cause: assert property ($rose(irq_pin_second_o)
      |-> $past(sample_valid_i, 2) || $past(reg_wr_i, 2))
      else $error("second pin rose without cause");
   chk_wake_cause: assert property ($changed(wake_mode_o)
      |-> $past(reg_wr_i) || $past(sample_valid_i) || $past(rst_i))
      else $error("wake mode moved without cause");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
      else $error("read data outside read cycle");
   chk_unmapped_read: assert property (reg_rd_i && reg_addr_i > OFS_MAP_SECOND |=> reg_rdata_o == '0)
      else $error("unmapped read not zero");
   cover property ($rose(awake_o));
   cover property ($fell(awake_o));
   cover property ($rose(wake_mode_o));
   cover property ($rose(irq_pin_second_o));
endmodule
bind mad_detector mad_detector_properties #(.WAKE_DIV(WAKE_DIV)) mad_detector_properties_i (
   .clk_i            (clk_i),
   .rst_i            (rst_i),
   .sample_valid_i   (sample_valid_i),
   .reg_addr_i       (reg_addr_i),
   .reg_wr_i         (reg_wr_i),
   .reg_rd_i         (reg_rd_i),
   .reg_rdata_o      (reg_rdata_o),
   .irq_pin_first_o  (irq_pin_first_o),
   .irq_pin_second_o (irq_pin_second_o),
   .awake_o          (awake_o),
   .wake_mode_o      (wake_mode_o),
   .measuring_o      (measuring_o)
);
`default_nettype wire

// File: verification/mad_detector_test.sv
// Self-checking testbench of the motion activity detector.
`timescale 1ns/100ps
`default_nettype none
module mad_detector_test;
   import mad_pkg::*;
   localparam int WD = 2;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              go = 1'b0;
   mad_sample_t       val = '0;
   mad_sample_t       smp;
   logic              smp_v;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              pin1, pin2, awake, wake, meas;
   int                err_count = 0;
   int                samples_checked = 0;
   logic [DATA_W-1:0] d, v;
   mad_sample_t       base, s;
   logic [7:0]        ofs[4] = '{OFS_ACT_THR, OFS_ACT_TIME, OFS_INACT_THR, OFS_INACT_TIME};
   logic [31:0]       msk[4] = '{32'h0000_07FF, 32'h0000_00FF, 32'h0000_07FF, 32'h0000_FFFF};

   mad_sensor_model mad_sensor_model_i (.clk_i(clk_i), .go_i(go), .val_i(val), .smp_o(smp),
                                        .valid_o(smp_v));
   mad_detector #(.WAKE_DIV(WD)) mad_detector_i (.clk_i(clk_i), .rst_i(rst_i), .sample_i(smp),
      .sample_valid_i(smp_v), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_pin_first_o(pin1), .irq_pin_second_o(pin2),
      .awake_o(awake), .wake_mode_o(wake), .measuring_o(meas));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic mad_sample_t mk(input int x, input int y, input int z);
      return '{x: 12'(x), y: 12'(y), z: 12'(z)};
   endfunction
   // Small axes stay within 20 counts; a big sample pushes one random axis past thr.
   function automatic mad_sample_t gen(input mad_sample_t b, input int thr, input logic big);
      int p[3];
      int k;
      foreach (p[i]) p[i] = int'($urandom % 41) - 20;
      k = $urandom % 3;
      if (big) p[k] = (thr + 41 + int'($urandom % 200)) * (($urandom % 2) ? 1 : -1);
      return mk(b.x + p[0], b.y + p[1], b.z + p[2]);
   endfunction
   function automatic logic [31:0] st(input logic a, input logic n, input logic w,
                                      input logic k, input logic m);
      st = '0;
      st[ST_ACT] = a;
      st[ST_INACT] = n;
      st[ST_AWAKE] = w;
      st[ST_WAKE] = k;
      st[ST_MEAS] = m;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_i);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 x = rdata;
   endtask
   task automatic put(input mad_sample_t x);
      @(posedge clk_i);
      go <= 1'b1;
      val <= x;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask
   task automatic burst(input mad_sample_t b, input int thr, input logic big, input int n);
      repeat (n) put(gen(b, thr, big));
   endtask
   task automatic conclude;
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      conclude();
   end

   initial begin
      void'($urandom(89));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_reg(OFS_STATUS, d);
      chk(d, '0);
      chk(32'({pin1, pin2, awake, wake, meas}), '0);
      rd_reg(8'h3C, d);
      chk(d, '0);
      foreach (ofs[i]) begin
         d = $urandom;
         wr_reg(ofs[i], d);
         rd_reg(ofs[i], v);
         chk(v, d & msk[i]);
      end
      // Absolute activity, three samples; a sample with every axis equal to the threshold breaks the run.
      wr_reg(OFS_ACT_THR, 32'h0000_0064);
      wr_reg(OFS_ACT_TIME, 32'h0000_0003);
      wr_reg(OFS_INACT_THR, 32'h0000_0032);
      wr_reg(OFS_INACT_TIME, 32'h0000_0004);
      wr_reg(OFS_MAP_FIRST, 32'h0000_0004);
      wr_reg(OFS_MAP_SECOND, 32'h0000_0001);
      wr_reg(OFS_CTL, 32'h0000_0001);
      wr_reg(OFS_PWR, 32'h0000_0001);
      base = '0;
      put(base);
      burst(base, 100, 1'b1, 2);
      put(mk(100, -100, 100));
      burst(base, 100, 1'b1, 2);
      chk(32'(awake), 32'h0000_0000);
      burst(base, 100, 1'b1, 1);
      chk(32'(awake), 32'h0000_0001);
      @(posedge clk_i);
      #1 chk(32'({pin1, pin2}), 32'h0000_0003);
      rd_reg(OFS_STATUS, d);
      chk(d, st(1, 0, 1, 0, 1));
      @(posedge clk_i);
      #1 chk(32'(pin2), 32'h0000_0000);
      rd_reg(OFS_STATUS, d);
      chk(d, st(0, 0, 1, 0, 1));
      // Default linking with autosleep set: the mode must not change.
      wr_reg(OFS_CTL, 32'h0000_0045);
      burst(base, 50, 1'b0, 3);
      put(mk(0, 50, 0));
      burst(base, 50, 1'b0, 3);
      chk(32'(awake), 32'h0000_0001);
      burst(base, 50, 1'b0, 1);
      chk(32'({awake, wake}), 32'h0000_0000);
      rd_reg(OFS_STATUS, d);
      chk(d, st(0, 1, 0, 0, 1));
      // Referenced loop mode with autosleep, around a tilted resting point.
      base = mk(900, -400, 300);
      wr_reg(OFS_ACT_TIME, 32'h0000_0002);
      wr_reg(OFS_INACT_TIME, 32'h0000_0003);
      wr_reg(OFS_CTL, 32'h0000_0000);
      wr_reg(OFS_CTL, 32'h0000_007F);
      burst(base, 100, 1'b0, 5);
      chk(32'(awake), 32'h0000_0000);
      burst(base, 100, 1'b1, 2);
      chk(32'(awake), 32'h0000_0001);
      burst(base, 50, 1'b0, 3);
      chk(32'(awake), 32'h0000_0001);
      burst(base, 50, 1'b0, 1);
      chk(32'({awake, wake}), 32'h0000_0001);
      // Pairs of pulses so the decimated wake-up mode takes exactly one of each.
      put(base);
      put(base);
      s = gen(base, 100, 1'b1);
      put(s);
      put(s);
      chk(32'({awake, wake}), 32'h0000_0002);
      // Linked absolute mode: the next detection waits for the host.
      base = '0;
      wr_reg(OFS_CTL, 32'h0000_0015);
      rd_reg(OFS_STATUS, d);
      burst(base, 50, 1'b0, 5);
      chk(32'(awake), 32'h0000_0000);
      burst(base, 100, 1'b1, 4);
      chk(32'(awake), 32'h0000_0000);
      rd_reg(OFS_STATUS, d);
      chk(d, st(0, 1, 0, 0, 1));
      burst(base, 100, 1'b1, 3);
      chk(32'(awake), 32'h0000_0001);
      // Standby keeps the pending event and ignores samples.
      wr_reg(OFS_PWR, 32'h0000_0003);
      #1 chk(32'(wake), 32'h0000_0001);
      wr_reg(OFS_PWR, 32'h0000_0000);
      burst(base, 50, 1'b0, 5);
      rd_reg(OFS_STATUS, d);
      chk(d, st(1, 0, 1, 0, 0));
      conclude();
   end
endmodule
`default_nettype wire
